// file: rtl/iesbf_pkg.sv
// Constants and types shared by the serial EEPROM bus front end
package iesbf_pkg;

  // ----------------------------------------------------------------
  // Clock rates
  // ----------------------------------------------------------------
  localparam int REF_PERIOD_NS = 8;
  localparam int LINK_PERIOD_NS = 64;
  localparam int NS_PER_MS = 1000000;

  // ----------------------------------------------------------------
  // Input spike filter: a least time, so round up
  // ----------------------------------------------------------------
  localparam int T_LP_NS = 100;
  localparam int FILT_CYC = (T_LP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Self-timed write cycle: longest times, so round down
  // ----------------------------------------------------------------
  localparam int T_WRITE_MS = 10;
  localparam int T_WRITE_LONG_MS = 20;
  localparam int WRITE_CYC = T_WRITE_MS * NS_PER_MS / REF_PERIOD_NS;
  localparam int WRITE_LONG_CYC = T_WRITE_LONG_MS * NS_PER_MS / REF_PERIOD_NS;
  localparam int TIMER_W = 22;

  // ----------------------------------------------------------------
  // Byte framing and select code layout
  // ----------------------------------------------------------------
  localparam int STRAP_W = 3;
  localparam int TYPE_W = 4;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int SEL_RW_POS = 0;
  localparam logic [1:0] WR_BYTES_MIN = 2'h2;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [TYPE_W-1:0] DEV_TYPE_DEFAULT = 4'h5; // Arbitrary value

  // ----------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } iesbf_state_e;

endpackage : iesbf_pkg

// file: rtl/iesbf_filter.sv
// Two-flop synchroniser followed by a stability filter for one bus line
`timescale 1ns/1ns
module iesbf_filter #(
  parameter int STABLE = 2,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_pin,
  output logic o_level
);

  logic sync1_q;
  logic sync2_q;
  logic [3:0] cnt_q;

  // ----------------------------------------------------------------
  // Synchroniser: first flop feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= RST_VAL;
      sync2_q <= RST_VAL;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
    end
  end

  // Accept a new level only after it held STABLE samples; shorter spikes vanish
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= 4'h0;
      o_level <= RST_VAL;
    end else if (sync2_q == o_level) begin
      cnt_q <= 4'h0;
    end else if (cnt_q == 4'(STABLE - 1)) begin
      cnt_q <= 4'h0;
      o_level <= sync2_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

endmodule : iesbf_filter

// file: rtl/iesbf_frontend.sv
// Slave bus front end of a two-wire serial EEPROM with write-cycle timer
`timescale 1ns/1ns
module iesbf_frontend
  import iesbf_pkg::*;
#(
  parameter logic [TYPE_W-1:0] DEV_TYPE = DEV_TYPE_DEFAULT,
  parameter int WRITE_CYCLES = WRITE_CYC,
  parameter int WRITE_LONG_CYCLES = WRITE_LONG_CYC,
  parameter int FILTER_CYCLES = FILT_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_link_clk,
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [STRAP_W-1:0] i_chip_select_straps,
  input wire logic [7:0] i_tx_byte,
  output logic o_tx_taken,
  output logic [7:0] o_rx_byte,
  output logic o_rx_valid,
  output logic o_start,
  output logic o_stop,
  output logic o_selected,
  output logic o_read_mode,
  output logic o_standby,
  input wire logic i_double_write_time,
  output logic o_write_busy
);

  // ----------------------------------------------------------------
  // Link domain signals
  // ----------------------------------------------------------------
  logic scl_f;
  logic sda_f;
  logic scl_p_q;
  logic sda_p_q;
  logic [STRAP_W-1:0] strap_s1_q;
  logic [STRAP_W-1:0] strap_s2_q;
  logic busy_s1_q;
  logic busy_s2_q;
  logic pend_q;
  logic ignore;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  iesbf_state_e state_q;
  logic [2:0] bit_q;
  logic full_q;
  logic sel_phase_q;
  logic [7:0] sh_q;
  logic rd_q;
  logic mack_q;
  logic nack_q;
  logic [1:0] wr_cnt_q;
  logic wr_tog_q;
  logic addr_match;

  // ----------------------------------------------------------------
  // Reference domain signals
  // ----------------------------------------------------------------
  logic [2:0] wr_s_q;
  logic wr_evt;
  logic [TIMER_W-1:0] timer_q;

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  // Clock line is input only: the device never drives it
  iesbf_filter #(
    .STABLE(FILTER_CYCLES),
    .RST_VAL(1'b1)
  ) u_scl_filter (
    .i_clk(i_link_clk),
    .i_reset(i_reset),
    .i_pin(i_scl),
    .o_level(scl_f)
  );

  // Data line filter; sees our own drive as well as the master's
  iesbf_filter #(
    .STABLE(FILTER_CYCLES),
    .RST_VAL(1'b1)
  ) u_sda_filter (
    .i_clk(i_link_clk),
    .i_reset(i_reset),
    .i_pin(i_sda_in),
    .o_level(sda_f)
  );

  // Straps may be driven dynamically, so they are synchronised too
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      strap_s1_q <= '0;
      strap_s2_q <= '0;
    end else begin
      strap_s1_q <= i_chip_select_straps;
      strap_s2_q <= strap_s1_q;
    end
  end

  // Previous filtered levels for edge and condition detection
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  // Bus conditions and clock edges
  assign start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_det = scl_f & scl_p_q & ~sda_p_q & sda_f;
  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;

  // Select match: type code then strap bits, R/W excluded
  assign addr_match = (sh_q[7:1] == {DEV_TYPE, strap_s2_q});

  // ----------------------------------------------------------------
  // Write-cycle busy crossing into the link domain
  // ----------------------------------------------------------------
  // Pend covers the round trip until the timer's busy arrives back
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      busy_s1_q <= o_write_busy;
      busy_s2_q <= busy_s1_q;
      if (stop_det && !ignore && !rd_q && o_selected && wr_cnt_q == WR_BYTES_MIN) begin
        pend_q <= 1'b1;
      end else if (busy_s2_q) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Lines are monitored except while programming runs
  assign ignore = pend_q | busy_s2_q;

  // ----------------------------------------------------------------
  // Link state machine and shift register
  // ----------------------------------------------------------------
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      bit_q <= 3'h0;
      full_q <= 1'b0;
      sel_phase_q <= 1'b0;
      sh_q <= SHIFT_RESET;
      rd_q <= 1'b0;
      mack_q <= 1'b0;
      nack_q <= 1'b0;
      o_sda_oe <= 1'b0;
      o_selected <= 1'b0;
    end else if (ignore) begin
      // Programming: deaf to the bus, so select bytes go unanswered
      state_q <= ST_IDLE;
      o_sda_oe <= 1'b0;
      o_selected <= 1'b0;
      nack_q <= 1'b0;
    end else if (start_det) begin
      // Also a repeated START: restart at the select byte
      state_q <= ST_RX;
      bit_q <= 3'h0;
      full_q <= 1'b0;
      sel_phase_q <= 1'b1;
      nack_q <= 1'b0;
      o_sda_oe <= 1'b0;
      o_selected <= 1'b0;
    end else if (stop_det) begin
      // Any transfer in flight is dropped
      state_q <= ST_IDLE;
      o_sda_oe <= 1'b0;
      o_selected <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          o_sda_oe <= 1'b0;
        end
        ST_RX: begin
          if (scl_rise && !full_q) begin
            // Master keeps data stable over the rise
            sh_q <= {sh_q[6:0], sda_f};
            bit_q <= bit_q + 3'h1;
            full_q <= (bit_q == BIT_LAST);
          end else if (scl_fall && full_q) begin
            full_q <= 1'b0;
            bit_q <= 3'h0;
            if (!sel_phase_q || addr_match) begin
              state_q <= ST_ACK;
              o_sda_oe <= 1'b1;
            end else begin
              state_q <= ST_IDLE;
            end
            if (sel_phase_q) begin
              rd_q <= sh_q[SEL_RW_POS];
              o_selected <= addr_match;
            end
            sel_phase_q <= 1'b0;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            // End of ninth clock; next bit changes only after this fall
            if (rd_q) begin
              state_q <= ST_TX;
              sh_q <= i_tx_byte;
              o_sda_oe <= ~i_tx_byte[7];
            end else begin
              state_q <= ST_RX;
              o_sda_oe <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_q <= bit_q + 3'h1;
            full_q <= (bit_q == BIT_LAST);
          end else if (scl_fall) begin
            if (full_q) begin
              // Eight bits out: free the line for the master's answer
              state_q <= ST_MACK;
              o_sda_oe <= 1'b0;
              full_q <= 1'b0;
              bit_q <= 3'h0;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              o_sda_oe <= ~sh_q[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_f;
          end else if (scl_fall) begin
            if (mack_q) begin
              state_q <= ST_TX;
              sh_q <= i_tx_byte;
              o_sda_oe <= ~i_tx_byte[7];
            end else begin
              // Not acknowledged: stay off the bus until STOP or START
              state_q <= ST_IDLE;
              nack_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Open-drain data: only ever pulled low
  assign o_sda_out = 1'b0;
  assign o_read_mode = rd_q;

  // ----------------------------------------------------------------
  // Event pulses and received data
  // ----------------------------------------------------------------
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      o_start <= 1'b0;
      o_stop <= 1'b0;
      o_rx_valid <= 1'b0;
      o_tx_taken <= 1'b0;
      o_rx_byte <= SHIFT_RESET;
    end else begin
      o_start <= start_det & ~ignore;
      o_stop <= stop_det & ~ignore;
      o_rx_valid <= 1'b0;
      o_tx_taken <= 1'b0;
      if (!ignore && !start_det && !stop_det && scl_fall) begin
        if (state_q == ST_RX && full_q && !sel_phase_q) begin
          o_rx_valid <= 1'b1;
          o_rx_byte <= sh_q;
        end
        if ((state_q == ST_ACK && rd_q) || (state_q == ST_MACK && mack_q)) begin
          o_tx_taken <= 1'b1;
        end
      end
    end
  end

  // Write bytes after select; address alone (dummy write) never programs
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_cnt_q <= 2'h0;
    end else if (start_det || ignore) begin
      wr_cnt_q <= 2'h0;
    end else if (state_q == ST_RX && scl_fall && full_q && !sel_phase_q && wr_cnt_q != WR_BYTES_MIN) begin
      wr_cnt_q <= wr_cnt_q + 2'h1;
    end
  end

  // Standby after STOP that follows a NACK; woken by START
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      o_standby <= 1'b1;
    end else if (ignore) begin
      o_standby <= 1'b0;
    end else if (start_det) begin
      o_standby <= 1'b0;
    end else if (stop_det && nack_q && rd_q) begin
      o_standby <= 1'b1;
    end
  end

  // STOP closing a write: toggle carries the trigger across domains
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_tog_q <= 1'b0;
    end else if (stop_det && !ignore && !rd_q && o_selected && wr_cnt_q == WR_BYTES_MIN) begin
      wr_tog_q <= ~wr_tog_q;
    end
  end

  // ----------------------------------------------------------------
  // Reference domain: write-cycle timer
  // ----------------------------------------------------------------
  // Third stage only for edge detect; detector never reads stage one
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_s_q <= 3'h0;
    end else begin
      wr_s_q <= {wr_s_q[1:0], wr_tog_q};
    end
  end

  assign wr_evt = wr_s_q[2] ^ wr_s_q[1];

  // Runs the full worst-case time; no early finish is modelled
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      timer_q <= '0;
    end else if (wr_evt && timer_q == '0) begin
      timer_q <= i_double_write_time ? TIMER_W'(WRITE_LONG_CYCLES) : TIMER_W'(WRITE_CYCLES);
    end else if (timer_q != '0) begin
      timer_q <= timer_q - TIMER_W'(1);
    end
  end

  // Busy flag registered from the counter state and the trigger event
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_write_busy <= 1'b0;
    end else begin
      o_write_busy <= (timer_q > TIMER_W'(1)) || (wr_evt && timer_q == '0);
    end
  end

endmodule : iesbf_frontend

// file: bench/iesbf_frontend_asserts.sv
// Port-level checks for the serial EEPROM bus front end
`timescale 1ns/1ns
module iesbf_chk
  import iesbf_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYC,
  parameter int WRITE_LONG_CYCLES = WRITE_LONG_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_link_clk,
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire logic o_sda_oe,
  input wire logic o_start,
  input wire logic o_stop,
  input wire logic o_selected,
  input wire logic o_standby,
  input wire logic o_rx_valid,
  input wire logic i_double_write_time,
  input wire logic o_write_busy
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [31:0] busy_cnt_q;
  logic long_q;

  // Busy length in reference cycles
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      busy_cnt_q <= 32'h0;
    end else begin
      busy_cnt_q <= o_write_busy ? busy_cnt_q + 32'h1 : 32'h0;
    end
  end

  // Limit chosen as the cycle starts, so a late change is ignored
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      long_q <= 1'b0;
    end else if (!o_write_busy) begin
      long_q <= i_double_write_time;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_start_seen;
    @(posedge i_link_clk) disable iff (i_reset)
    $fell(i_sda_in) && i_scl && !o_write_busy |-> ##[2:10] o_start;
  endproperty
  a_start_seen: assert property (p_start_seen)
    else $error("start not reported");
  property p_stop_seen;
    @(posedge i_link_clk) disable iff (i_reset)
    $rose(i_sda_in) && i_scl && !o_write_busy |-> ##[2:10] o_stop;
  endproperty
  a_stop_seen: assert property (p_stop_seen)
    else $error("stop not reported");
  property p_stop_ends;
    @(posedge i_link_clk) disable iff (i_reset)
    o_stop |-> ##[0:2] (!o_selected && !o_sda_oe);
  endproperty
  a_stop_ends: assert property (p_stop_ends)
    else $error("transfer kept after stop");
  property p_oe_selected;
    @(posedge i_link_clk) disable iff (i_reset)
    o_sda_oe |-> o_selected;
  endproperty
  a_oe_selected: assert property (p_oe_selected)
    else $error("data line driven while not selected");
  property p_oe_scl_low;
    @(posedge i_link_clk) disable iff (i_reset)
    $changed(o_sda_oe) |-> !i_scl;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data drive changed with clock high");
  property p_busy_quiet;
    @(posedge i_link_clk) disable iff (i_reset)
    o_write_busy |-> !o_sda_oe && !o_start && !o_rx_valid;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("bus answered during write cycle");
  property p_busy_len;
    @(posedge i_ref_clk) disable iff (i_reset)
    $fell(o_write_busy) |-> busy_cnt_q <= (long_q ? WRITE_LONG_CYCLES : WRITE_CYCLES) + 2;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle too long");
  property p_standby_cause;
    @(posedge i_link_clk) disable iff (i_reset)
    $rose(o_standby) |-> o_stop || $past(o_stop) || $past(o_stop, 2);
  endproperty
  a_standby_cause: assert property (p_standby_cause)
    else $error("standby without stop");
  property p_start_clears;
    @(posedge i_link_clk) disable iff (i_reset)
    o_start |-> ##[0:2] (!o_selected && !o_standby);
  endproperty
  a_start_clears: assert property (p_start_clears)
    else $error("start left selection or standby");
endmodule : iesbf_chk

bind iesbf_frontend iesbf_chk #(
  .WRITE_CYCLES(WRITE_CYCLES),
  .WRITE_LONG_CYCLES(WRITE_LONG_CYCLES)
) i_iesbf_chk (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_link_clk(i_link_clk),
  .i_scl(i_scl), .i_sda_in(i_sda_in), .o_sda_oe(o_sda_oe),
  .o_start(o_start), .o_stop(o_stop), .o_selected(o_selected),
  .o_standby(o_standby), .o_rx_valid(o_rx_valid),
  .i_double_write_time(i_double_write_time), .o_write_busy(o_write_busy)
);

// file: bench/iesbf_master_model.sv
// Behavioural bus master that clocks and frames transfers
`timescale 1ns/1ns
module iesbf_master_model #(
  parameter int T_HIGH = 500,
  parameter int T_LOW = 600
) (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // Idle bus: clock parked high, data released
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask : idle

  // Start or repeated start; gap keeps data off the clock edge
  task automatic start_cond();
    idle(25);
    o_sda_low <= 1'b0;
    idle(T_LOW);
    o_scl <= 1'b1;
    idle(T_LOW);
    o_sda_low <= 1'b1;
    idle(T_HIGH);
    o_scl <= 1'b0;
  endtask : start_cond

  // One bit, data moved only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    idle(25);
    o_sda_low <= !b;
    idle(T_LOW);
    o_scl <= 1'b1;
    idle(T_HIGH);
    r = i_sda;
    o_scl <= 1'b0;
  endtask : bit_io

  // Byte MSB first, then ninth bit; ack_in 1 leaves the line free
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(ack_in, ack_out);
  endtask : xfer

  task automatic stop_cond();
    idle(25);
    o_sda_low <= 1'b1;
    idle(T_LOW);
    o_scl <= 1'b1;
    idle(T_LOW);
    o_sda_low <= 1'b0;
    idle(T_LOW);
  endtask : stop_cond
endmodule : iesbf_master_model

// file: bench/tb.sv
// Self-checking bench for the bus front end
`timescale 1ns/1ns
module tb
  import iesbf_pkg::*;
;
  localparam int WR_CYC = 7500;
  localparam logic [2:0] STRAPS = 3'h5;
  logic ref_clk, link_clk, reset, dbl, scl, m_low, sda, ack;
  logic oe, sda_out, tx_taken, rx_valid, start_p, stop_p, selected, read_mode, standby, busy;
  logic [2:0] straps;
  logic [7:0] tx_byte, rx_byte, rx_last, rd;
  int err_count, compares;
  // Monitor counters start at zero; only the monitors below write them
  int rx_cnt = 0, tx_cnt = 0, busy_len = 0;

  // ----------------------------------------------------------------
  // Clocks, wire and monitors
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #32 link_clk = ~link_clk;
  end
  // Open drain with pull-up; the device's data level counts only while enabled
  assign sda = !m_low && (oe ? sda_out : 1'b1);
  always @(posedge link_clk) begin
    if (rx_valid === 1'b1) begin
      rx_last <= rx_byte;
      rx_cnt <= rx_cnt + 1;
    end
    if (tx_taken === 1'b1) tx_cnt <= tx_cnt + 1;
  end
  always @(posedge ref_clk) begin
    if (busy === 1'b1) busy_len <= busy_len + 1;
  end

  iesbf_frontend #(
    .WRITE_CYCLES(WR_CYC),
    .WRITE_LONG_CYCLES(2 * WR_CYC)
  ) i_iesbf_frontend (
    .i_ref_clk(ref_clk), .i_reset(reset), .i_link_clk(link_clk), .i_scl(scl), .i_sda_in(sda),
    .o_sda_out(sda_out), .o_sda_oe(oe), .i_chip_select_straps(straps), .i_tx_byte(tx_byte),
    .o_tx_taken(tx_taken), .o_rx_byte(rx_byte), .o_rx_valid(rx_valid), .o_start(start_p),
    .o_stop(stop_p), .o_selected(selected), .o_read_mode(read_mode), .o_standby(standby),
    .i_double_write_time(dbl), .o_write_busy(busy)
  );
  iesbf_master_model i_iesbf_master_model (.i_clk(ref_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic close_out();
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // Bounded wait on busy; running out ends the run
  task automatic wait_busy(input logic lvl, input int limit);
    int n;
    n = 0;
    while (busy !== lvl) begin
      if (n == limit) begin
        check("busy wait", lvl, busy);
        close_out();
      end
      n++;
      @(posedge ref_clk);
    end
  endtask : wait_busy

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_write();
    // Long write time, so the doubled limit is exercised by the poll below
    dbl <= 1'b1;
    i_iesbf_master_model.start_cond();
    i_iesbf_master_model.xfer({DEV_TYPE_DEFAULT, STRAPS, 1'b0}, 1'b1, rd, ack);
    check("select ack", 1'h0, ack);
    check("selected", 1'h1, selected);
    check("read mode", 1'h0, read_mode);
    i_iesbf_master_model.xfer(8'h3C, 1'b1, rd, ack);
    check("address", 8'h3C, rx_last);
    i_iesbf_master_model.xfer(8'hC3, 1'b1, rd, ack);
    check("data ack", 1'h0, ack);
    check("data", 8'hC3, rx_last);
    check("rx count", 2, rx_cnt);
    i_iesbf_master_model.stop_cond();
    wait_busy(1'b1, 10);
  endtask : sc_write

  // Select during the write cycle is ignored
  task automatic sc_poll();
    i_iesbf_master_model.start_cond();
    i_iesbf_master_model.xfer({DEV_TYPE_DEFAULT, STRAPS, 1'b0}, 1'b1, rd, ack);
    check("busy ack", 1'h1, ack);
    check("busy selected", 1'h0, selected);
    i_iesbf_master_model.stop_cond();
    check("still busy", 1'h1, busy);
    wait_busy(1'b0, 4000);
    check("busy length", 1'h1, busy_len >= 2 * WR_CYC - 2 && busy_len <= 2 * WR_CYC + 2);
  endtask : sc_poll

  // Aborted byte, repeated start, one byte read then refused
  task automatic sc_read();
    tx_byte <= 8'h96;
    i_iesbf_master_model.start_cond();
    for (int i = 0; i < 3; i++) i_iesbf_master_model.bit_io(1'b0, ack);
    i_iesbf_master_model.start_cond();
    i_iesbf_master_model.xfer({DEV_TYPE_DEFAULT, STRAPS, 1'b1}, 1'b1, rd, ack);
    check("read ack", 1'h0, ack);
    check("read mode", 1'h1, read_mode);
    check("standby low", 1'h0, standby);
    i_iesbf_master_model.xfer(8'hFF, 1'b1, rd, ack);
    check("read byte", 8'h96, rd);
    check("tx count", 1, tx_cnt);
    i_iesbf_master_model.stop_cond();
    check("standby", 1'h1, standby);
    check("deselected", 1'h0, selected);
  endtask : sc_read

  // Other strap bits: no ack, line left free
  task automatic sc_mismatch();
    i_iesbf_master_model.start_cond();
    i_iesbf_master_model.xfer({DEV_TYPE_DEFAULT, STRAPS ^ 3'h7, 1'b0}, 1'b1, rd, ack);
    check("foreign ack", 1'h1, ack);
    check("foreign selected", 1'h0, selected);
    i_iesbf_master_model.stop_cond();
  endtask : sc_mismatch

  // Reset across both clocks, then the scenarios
  initial begin
    err_count = 0;
    compares = 0;
    reset = 1'b1;
    straps = STRAPS;
    tx_byte = 8'h00;
    dbl = 1'b0;
    repeat (8) @(posedge link_clk);
    @(posedge ref_clk);
    reset <= 1'b0;
    repeat (80) @(posedge ref_clk);
    sc_write();
    sc_poll();
    sc_read();
    sc_mismatch();
    close_out();
  end
endmodule : tb
